// File: nopg_params.svh
`ifndef NOPG_PARAMS_SVH
`define NOPG_PARAMS_SVH

// Register byte addresses on the APB
`define NOPG_ADDR_TSTART 24'hFFFB00
`define NOPG_ADDR_CMPA 24'hFFFB04
`define NOPG_ADDR_CMPB 24'hFFFB08
`define NOPG_ADDR_COUNT 24'hFFFB0C
`define NOPG_ADDR_OUTEN 24'hFFFB10
`define NOPG_ADDR_OUTDATA 24'hFFFB14
`define NOPG_ADDR_STAGE 24'hFFFB18
`define NOPG_ADDR_OUTCTRL 24'hFFFB1C
`define NOPG_ADDR_IRQSTS 24'hFFFB20
`define NOPG_ADDR_IRQCLR 24'hFFFB24
`define NOPG_ADDR_IRQEN 24'hFFFB28

// Field positions
`define NOPG_RUN_BIT 0
`define NOPG_XFER_LSB 0
`define NOPG_XFER_MSB 7
`define NOPG_NOV_LSB 8
`define NOPG_NOV_MSB 15
`define NOPG_IRQ_A_BIT 0
`define NOPG_IRQ_B_BIT 1

// Reset values and counter step
`define NOPG_RUN_RST 1'h0
`define NOPG_CMPA_RST 16'hFFFF
`define NOPG_CMPB_RST 16'hFFFF
`define NOPG_CNT_RST 16'h0000
`define NOPG_WORD_RST 32'h00000000
`define NOPG_CTRL_RST 16'h0000
`define NOPG_IRQ_RST 2'h0
`define NOPG_CNT_STEP 16'h0001

`endif

// File: nopg_pkg.sv
`default_nettype none
package nopg_pkg;
  typedef logic [3:0] nopg_nib_t;
  typedef logic [15:0] nopg_cnt_t;
  typedef logic [1:0] nopg_irq_t;
  typedef enum logic [1:0] {
    NOPG_BUS_IDLE = 2'b01,
    NOPG_BUS_ACK = 2'b10
  } nopg_bus_t;
endpackage
`default_nettype wire

// File: nopg_group_xfer.sv
`timescale 1ns/1ps
`default_nettype none
module nopg_group_xfer
  import nopg_pkg::*;
(
  input wire nopg_nib_t curData,
  input wire nopg_nib_t stageData,
  input wire logic xferEn,
  input wire logic nonOverlap,
  input wire logic matchA,
  input wire logic matchB,
  output var nopg_nib_t nextData
);
  always_comb begin
    nextData = curData;
    if (xferEn && matchA) begin
      nextData = stageData; // [RULE5] [RULE7]
    end else if (xferEn && nonOverlap && matchB) begin
      // Only zeros pass: the output is old AND new meanwhile
      nextData = curData & stageData; // [RULE8] [RULE13]
    end
  end
endmodule // nopg_group_xfer
`default_nettype wire

// File: nopg_pulse_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "nopg_params.svh"
// Notes on behaviour
// [RULE1] Output updates are timed by compare matches of a 16-bit counter.
// [RULE2] Outputs form eight independent 4-bit groups, seven down to zero.
// [RULE3] A pin is driven only while its output enable bit is one.
// [RULE4] Enabled pins show the output data software loaded before transfers.
// [RULE5] Selected compare match copies a group's staging bits to output data.
// [RULE6] Writer loads each new staging value before the next compare match.
// [RULE7] Non-overlap mode: match A copies all staging bits of the group.
// [RULE8] Non-overlap mode: match B copies only zero staging bits.
// [RULE9] Timer is programmed so match B comes before match A.
// [RULE10] Writer leaves staging alone between match B and next match A.
// [RULE11] Next staging value is written after match A, before next match B.
// [RULE12] Match A raises an interrupt request for handler or transfer unit.
// [RULE13] During non-overlap period a bit is one only if old and new are one.
// [RULE14] Start register bit 0 runs the channel six counter when set.
// [RULE15] Staging writes never reach pins; only transfers or data writes do.
module nopg_pulse_gen
  import nopg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [23:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] pulseOut,
  output logic [31:0] pulseOe,
  output logic matchAReq,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, answer registered
  nopg_bus_t busSt_r, busSt_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  logic wrStrobe;
  logic addrHit;
  logic [31:0] readMux;

  logic counterRun_r, counterRun_nxt;
  nopg_cnt_t cmpA_r, cmpA_nxt;
  nopg_cnt_t cmpB_r, cmpB_nxt;
  nopg_cnt_t cnt_r, cnt_nxt;
  logic [31:0] outEn_r, outEn_nxt;
  logic [31:0] outData_r, outData_nxt;
  logic [31:0] stage_r, stage_nxt;
  logic [15:0] outCtrl_r, outCtrl_nxt;
  nopg_irq_t irqSts_r, irqSts_nxt;
  nopg_irq_t irqEn_r, irqEn_nxt;
  logic [31:0] pulseOut_r, pulseOut_nxt;
  logic [31:0] pulseOe_r, pulseOe_nxt;
  logic matchAReq_r, irq_r;
  logic matchA, matchB;
  logic [31:0] xferData;

  always_comb begin
    readMux = `NOPG_WORD_RST;
    addrHit = 1'b1;
    unique case (paddr)
      `NOPG_ADDR_TSTART: readMux[`NOPG_RUN_BIT] = counterRun_r;
      `NOPG_ADDR_CMPA: readMux[15:0] = cmpA_r;
      `NOPG_ADDR_CMPB: readMux[15:0] = cmpB_r;
      `NOPG_ADDR_COUNT: readMux[15:0] = cnt_r;
      `NOPG_ADDR_OUTEN: readMux = outEn_r;
      `NOPG_ADDR_OUTDATA: readMux = outData_r;
      `NOPG_ADDR_STAGE: readMux = stage_r;
      `NOPG_ADDR_OUTCTRL: readMux[15:0] = outCtrl_r;
      `NOPG_ADDR_IRQSTS: readMux[1:0] = irqSts_r;
      `NOPG_ADDR_IRQCLR: readMux = `NOPG_WORD_RST;
      `NOPG_ADDR_IRQEN: readMux[1:0] = irqEn_r;
      default: addrHit = 1'b0;
    endcase
  end

  always_comb begin
    busSt_nxt = busSt_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    unique case (busSt_r)
      NOPG_BUS_IDLE: begin
        if (psel && penable) begin
          busSt_nxt = NOPG_BUS_ACK;
          prdata_nxt = pwrite ? `NOPG_WORD_RST : readMux;
          pslverr_nxt = !addrHit;
        end
      end
      NOPG_BUS_ACK: begin
        busSt_nxt = NOPG_BUS_IDLE;
        prdata_nxt = `NOPG_WORD_RST;
        pslverr_nxt = 1'b0;
      end
      default: busSt_nxt = NOPG_BUS_IDLE;
    endcase
  end

  // Writes land at the edge that samples pready high
  assign wrStrobe = psel && penable && pwrite && (busSt_r == NOPG_BUS_ACK);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busSt_r <= NOPG_BUS_IDLE;
      prdata_r <= `NOPG_WORD_RST;
      pslverr_r <= 1'b0;
    end else begin
      busSt_r <= busSt_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign pready = (busSt_r == NOPG_BUS_ACK);
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Time base counter, cleared at match B
  assign matchA = counterRun_r && (cnt_r == cmpA_r); // [RULE1]
  assign matchB = counterRun_r && (cnt_r == cmpB_r); // [RULE1]

  always_comb begin
    counterRun_nxt = counterRun_r;
    cmpA_nxt = cmpA_r;
    cmpB_nxt = cmpB_r;
    cnt_nxt = cnt_r;
    if (counterRun_r) begin
      cnt_nxt = matchB ? `NOPG_CNT_RST : cnt_r + `NOPG_CNT_STEP; // [RULE14]
    end
    if (wrStrobe) begin
      unique case (paddr)
        `NOPG_ADDR_TSTART: counterRun_nxt = pwdata[`NOPG_RUN_BIT]; // [RULE14]
        `NOPG_ADDR_CMPA: cmpA_nxt = pwdata[15:0];
        `NOPG_ADDR_CMPB: cmpB_nxt = pwdata[15:0];
        `NOPG_ADDR_COUNT: cnt_nxt = pwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      counterRun_r <= `NOPG_RUN_RST;
      cmpA_r <= `NOPG_CMPA_RST;
      cmpB_r <= `NOPG_CMPB_RST;
      cnt_r <= `NOPG_CNT_RST;
    end else begin
      counterRun_r <= counterRun_nxt;
      cmpA_r <= cmpA_nxt;
      cmpB_r <= cmpB_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse groups
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gGroup
      nopg_group_xfer uXfer ( // [RULE2]
        .curData(outData_r[4*g +: 4]),
        .stageData(stage_r[4*g +: 4]),
        .xferEn(outCtrl_r[`NOPG_XFER_LSB + g]),
        .nonOverlap(outCtrl_r[`NOPG_NOV_LSB + g]),
        .matchA(matchA),
        .matchB(matchB),
        .nextData(xferData[4*g +: 4])
      );
    end
  endgenerate

  always_comb begin
    outEn_nxt = outEn_r;
    stage_nxt = stage_r;
    outCtrl_nxt = outCtrl_r;
    // A direct data write is overridden by a same-cycle transfer
    outData_nxt = (wrStrobe && paddr == `NOPG_ADDR_OUTDATA) ?
                  pwdata : outData_r; // [RULE4]
    if (matchA || matchB) begin
      outData_nxt = xferData; // [RULE5]
    end
    if (wrStrobe) begin
      unique case (paddr)
        `NOPG_ADDR_OUTEN: outEn_nxt = pwdata;
        `NOPG_ADDR_STAGE: stage_nxt = pwdata; // [RULE15]
        `NOPG_ADDR_OUTCTRL: outCtrl_nxt = pwdata[15:0];
        default: ;
      endcase
    end
    pulseOut_nxt = outData_nxt & outEn_nxt; // [RULE3] [RULE4]
    pulseOe_nxt = outEn_nxt; // [RULE3]
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      outEn_r <= `NOPG_WORD_RST;
      outData_r <= `NOPG_WORD_RST;
      stage_r <= `NOPG_WORD_RST;
      outCtrl_r <= `NOPG_CTRL_RST;
      pulseOut_r <= `NOPG_WORD_RST;
      pulseOe_r <= `NOPG_WORD_RST;
    end else begin
      outEn_r <= outEn_nxt;
      outData_r <= outData_nxt;
      stage_r <= stage_nxt;
      outCtrl_r <= outCtrl_nxt;
      pulseOut_r <= pulseOut_nxt;
      pulseOe_r <= pulseOe_nxt;
    end
  end

  assign pulseOut = pulseOut_r;
  assign pulseOe = pulseOe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, set beats clear
  always_comb begin
    irqSts_nxt = irqSts_r;
    irqEn_nxt = irqEn_r;
    if (wrStrobe && paddr == `NOPG_ADDR_IRQCLR) begin
      irqSts_nxt = irqSts_r & ~pwdata[1:0];
    end
    if (wrStrobe && paddr == `NOPG_ADDR_IRQEN) begin
      irqEn_nxt = pwdata[1:0];
    end
    if (matchA) begin
      irqSts_nxt[`NOPG_IRQ_A_BIT] = 1'b1; // [RULE12]
    end
    if (matchB) begin
      irqSts_nxt[`NOPG_IRQ_B_BIT] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irqSts_r <= `NOPG_IRQ_RST;
      irqEn_r <= `NOPG_IRQ_RST;
      matchAReq_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      irqSts_r <= irqSts_nxt;
      irqEn_r <= irqEn_nxt;
      matchAReq_r <= matchA; // [RULE12]
      irq_r <= |(irqSts_nxt & irqEn_nxt);
    end
  end

  assign matchAReq = matchAReq_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence apbSetupS;
    psel && !penable;
  endsequence
  sequence apbAccessS;
    psel && penable;
  endsequence

  apb_answer_a: assert property (
    apbSetupS ##1 apbAccessS |-> ##1 pready)
    else $error("APB access not answered in one wait state");

  pin_gate_a: assert property ( // [RULE3]
    (pulseOut & ~pulseOe) == `NOPG_WORD_RST)
    else $error("Pulse pin driven while disabled");

  pin_data_a: assert property ( // [RULE4]
    pulseOut == (outData_r & outEn_r))
    else $error("Pin value differs from output data");

  match_a_copy_a: assert property ( // [RULE7]
    matchA && outCtrl_r[`NOPG_XFER_LSB] |=>
    outData_r[3:0] == $past(stage_r[3:0]))
    else $error("Match A did not copy staging bits");

  match_b_zero_a: assert property ( // [RULE8]
    matchB && !matchA && outCtrl_r[`NOPG_XFER_LSB + 4] &&
    outCtrl_r[`NOPG_NOV_LSB + 4] |=>
    outData_r[19:16] == ($past(outData_r[19:16]) & $past(stage_r[19:16])))
    else $error("Match B copied more than zero bits");

  group_alone_a: assert property ( // [RULE2]
    matchA && !outCtrl_r[`NOPG_XFER_LSB + 1] && !wrStrobe |=>
    $stable(outData_r[7:4]))
    else $error("Disabled group changed on match");

  stage_isolated_a: assert property ( // [RULE15]
    !matchA && !matchB && !(wrStrobe && paddr == `NOPG_ADDR_OUTDATA) |=>
    $stable(outData_r))
    else $error("Output data changed without transfer");

  counter_step_a: assert property ( // [RULE1]
    counterRun_r && !matchB && !wrStrobe |=>
    cnt_r == 16'($past(cnt_r) + `NOPG_CNT_STEP))
    else $error("Counter did not advance");

  counter_hold_a: assert property ( // [RULE14]
    !counterRun_r && !wrStrobe |=> $stable(cnt_r))
    else $error("Counter moved while stopped");

  irq_raise_a: assert property ( // [RULE12]
    matchA && irqEn_nxt[`NOPG_IRQ_A_BIT] |=> irq && matchAReq)
    else $error("Match A raised no request");

endmodule // nopg_pulse_gen
`default_nettype wire

// File: nopg_pin_load.sv
`timescale 1ns/1ps
`default_nettype none
module nopg_pin_load (
  input wire logic [31:0] pulseOut,
  input wire logic [31:0] pulseOe,
  output logic [31:0] pinLevel
);
  // Pull-downs on the board: an undriven pin reads low, never the old value
  assign pinLevel = pulseOut & pulseOe;
endmodule // nopg_pin_load
`default_nettype wire

// File: tb_nonoverlap_pulse_pattern_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "nopg_params.svh"
module tb_nonoverlap_pulse_pattern_gen;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [23:0] paddr = 24'h000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, pulseOut, pulseOe, pinLevel, rdData;
  logic pready, pslverr, matchAReq, irq, busErr;
  logic [3:0] prevNib;
  logic [3:0] pattern [5] = '{4'h3, 4'hA, 4'hF, 4'h0, 4'h5};
  int fail_count = 0;
  int comparisons = 0;

  always #4 core_clk = ~core_clk;

  nopg_pulse_gen i_dut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulseOut(pulseOut), .pulseOe(pulseOe), .matchAReq(matchAReq),
    .irq(irq));
  nopg_pin_load i_load (.pulseOut(pulseOut), .pulseOe(pulseOe),
    .pinLevel(pinLevel));

  ////////////////////////////////////////
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic hang();
    $display("Wait expired at %0t", $time);
    fail_count++;
    report_and_stop();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic isWr, input logic [23:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= isWr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdData = prdata;
    busErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) hang();
    // Callers look at outputs only after this edge's updates have landed
    @(negedge core_clk);
  endtask

  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [23:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(rdData, e);
  endtask

  task automatic waitA();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (matchAReq !== 1'b1 && n < 100);
    if (matchAReq !== 1'b1) hang();
  endtask

  // Polls status, since match B has no pulse output of its own
  task automatic waitB();
    int n;
    n = 0;
    do begin
      bus(1'b0, `NOPG_ADDR_IRQSTS, 32'h00000000);
      n++;
    end while (rdData[1] !== 1'b1 && n < 15);
    if (rdData[1] !== 1'b1) hang();
  endtask

  // Groups 5 and 1 enabled but never transferred; they keep 9
  function automatic logic [31:0] pinWord(input logic [3:0] g4,
                                          input logic [3:0] g0);
    return {8'h00, 4'h9, g4, 8'h00, 4'h9, g0};
  endfunction

  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    chk(pulseOut, 32'h00000000);
    rd(`NOPG_ADDR_TSTART, 32'h00000000);
    rd(`NOPG_ADDR_CMPA, {16'h0000, `NOPG_CMPA_RST});
    rd(`NOPG_ADDR_CMPB, {16'h0000, `NOPG_CMPB_RST});
    rd(`NOPG_ADDR_COUNT, 32'h00000000);
    rd(`NOPG_ADDR_IRQSTS, 32'h00000000);
    rd(`NOPG_ADDR_IRQCLR, 32'h00000000);
    bus(1'b0, 24'hFFFB2C, 32'h00000000);
    chk({31'h0, busErr}, 32'h00000001);
    wr(`NOPG_ADDR_OUTDATA, 32'h00990099);
    wr(`NOPG_ADDR_OUTEN, 32'h00FF00FF);
    chk(pulseOe, 32'h00FF00FF);
    chk(pinLevel, pinWord(4'h9, 4'h9));
    wr(`NOPG_ADDR_STAGE, 32'h55555555);
    chk(pinLevel, pinWord(4'h9, 4'h9));
    wr(`NOPG_ADDR_OUTCTRL, 32'h00001011);
    rd(`NOPG_ADDR_OUTCTRL, 32'h00001011);
    wr(`NOPG_ADDR_CMPA, 32'h00000014);
    wr(`NOPG_ADDR_CMPB, 32'h0000003C);
    wr(`NOPG_ADDR_TSTART, 32'h00000001);
    rd(`NOPG_ADDR_TSTART, 32'h00000001);
    waitA();
    chk(pinLevel, pinWord(4'h5, 4'h5));
    chk({31'h0, irq}, 32'h00000000);
    rd(`NOPG_ADDR_IRQSTS, 32'h00000001);
    wr(`NOPG_ADDR_IRQEN, 32'h00000001);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h00000001);
    prevNib = 4'h5;
    foreach (pattern[i]) begin
      wr(`NOPG_ADDR_IRQCLR, 32'h00000003);
      wr(`NOPG_ADDR_STAGE, {8{pattern[i]}});
      chk({31'h0, irq}, 32'h00000000);
      chk(pinLevel, pinWord(prevNib, prevNib));
      waitB();
      chk(pinLevel, pinWord(prevNib & pattern[i], prevNib));
      waitA();
      chk(pinLevel, pinWord(pattern[i], pattern[i]));
      chk({31'h0, irq}, 32'h00000001);
      prevNib = pattern[i];
    end
    wr(`NOPG_ADDR_TSTART, 32'h00000000);
    wr(`NOPG_ADDR_COUNT, 32'h00000007);
    rd(`NOPG_ADDR_COUNT, 32'h00000007);
    rd(`NOPG_ADDR_COUNT, 32'h00000007);
    wr(`NOPG_ADDR_TSTART, 32'h00000001);
    waitA();
    report_and_stop();
  end
endmodule // tb_nonoverlap_pulse_pattern_gen
`default_nettype wire
